// ### bench/core_model.sv
// Behavioural model of the controller core that the register block observes
`timescale 1ns/10ps
`default_nettype none
module core_model (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  // Bench commands
  input  wire logic       i_load,
  input  wire logic [5:0] i_tx_lvl,
  input  wire logic [5:0] i_rx_lvl,
  input  wire logic       i_ev_start,
  input  wire logic       i_ev_call,
  // Control from the block
  input  wire logic       i_fifo_flush,
  // Observed by the block
  output logic [5:0]      o_tx_level,
  output logic [5:0]      o_rx_level,
  output logic            o_start_seen_irq,
  output logic            o_broadcast_call_irq
);
  // FIFO counts; a flush empties both and beats a load
  always_ff @(posedge i_mclk) begin
    if (!i_rstn || i_fifo_flush) begin
      o_tx_level <= 6'h00;
      o_rx_level <= 6'h00;
    end else if (i_load) begin
      o_tx_level <= i_tx_lvl;
      o_rx_level <= i_rx_lvl;
    end
  end
  // Events as one-cycle pulses
  always_ff @(posedge i_mclk) begin
    o_start_seen_irq     <= i_rstn & i_ev_start;
    o_broadcast_call_irq <= i_rstn & i_ev_call;
  end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the enable, status and level register block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int DEPTH = 32;
  // Clock, reset and bus drive
  logic        i_mclk = 1'b0;
  logic        i_rstn = 1'b0;
  logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_arvalid = 1'b0;
  wire logic   o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire logic [1:0]  o_bresp, o_rresp;
  wire logic [31:0] o_rdata;
  // Core side drive and block controls
  logic        mst = 1'b0, slv = 1'b0, txb = 1'b0, rxb = 1'b0, load = 1'b0, evs = 1'b0, evc = 1'b0;
  logic [5:0]  txl = 6'h00, rxl = 6'h00;
  wire logic [5:0]  tx_level, rx_level;
  wire logic   start_irq, call_irq, ctrl_en, flush, tx_disc, rx_nack, sclr, cclr, mhold, irq;
  wire logic [15:0] hold;
  // Bench state and expectations
  integer      seed = 32'hc4aa7a5a;
  int          mismatches = 0, n_tests = 0, cyc = 0, chg_cyc = 0, commit_cyc = 0, m_tx, m_rx;
  logic        en_seen = 1'b0, pulse_s, pulse_c;

  i2c_enable_status_regs #(.FIFO_DEPTH(DEPTH)) i2c_enable_status_regs_i (
    .i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(4'hf), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(1'b1),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(1'b1),
    .i_master_busy(mst), .i_slave_busy(slv), .i_tx_level(tx_level), .i_rx_level(rx_level),
    .i_start_seen_irq(start_irq), .i_broadcast_call_irq(call_irq),
    .i_tx_in_byte(txb), .i_rx_in_byte(rxb),
    .o_ctrl_enable(ctrl_en), .o_fifo_flush(flush), .o_tx_discard(tx_disc), .o_rx_nack(rx_nack),
    .o_start_seen_clear(sclr), .o_broadcast_call_clear(cclr), .o_masked_hold(mhold),
    .o_data_hold_cycles(hold), .o_irq(irq));

  core_model core_model_i (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_load(load), .i_tx_lvl(txl), .i_rx_lvl(rxl),
    .i_ev_start(evs), .i_ev_call(evc), .i_fifo_flush(flush), .o_tx_level(tx_level),
    .o_rx_level(rx_level), .o_start_seen_irq(start_irq), .o_broadcast_call_irq(call_irq));

  // Clock and edge counter
  always #12.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) cyc <= cyc + 1;
  // Edge at which the applied enable last changed
  always @(posedge i_mclk) begin
    if (ctrl_en !== en_seen) begin
      en_seen = ctrl_en;
      chg_cyc = cyc; // Changed at the previous edge
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Write with address and data offered together; commit edge recorded
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = i2c_regs_pkg::RESP_OKAY);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge i_mclk);
      if (!aw_ok && o_awready) begin
        aw_ok = 1'b1;
        i_awvalid <= 1'b0;
      end
      if (!w_ok && o_wready) begin
        w_ok = 1'b1;
        i_wvalid <= 1'b0;
      end
    end
    do @(posedge i_mclk); while (!o_bvalid);
    commit_cyc = cyc; // Edge at which the write landed
    chk({30'h0, o_bresp}, {30'h0, er});
  endtask

  // Read, also noting the clear pulses of the data cycle
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er = i2c_regs_pkg::RESP_OKAY);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do @(posedge i_mclk); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_mclk); while (!o_rvalid);
    pulse_s = sclr;
    pulse_c = cclr;
    chk(o_rdata, exp);
    chk({30'h0, o_rresp}, {30'h0, er});
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge i_mclk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    logic [31:0] d, es;
    int i;
    repeat (20) @(posedge i_mclk);
    i_rstn <= 1'b1;
    // Reset values and an unmapped place
    rchk(i2c_regs_pkg::ADDR_CONTROLLER_ENABLE, 32'h0);
    rchk(i2c_regs_pkg::ADDR_CONTROLLER_STATUS, 32'h6);
    rchk(i2c_regs_pkg::ADDR_TX_FILL_LEVEL, 32'h0);
    rchk(i2c_regs_pkg::ADDR_RX_FILL_LEVEL, 32'h0);
    rchk(i2c_regs_pkg::ADDR_DATA_HOLD_TIME, 32'h1);
    chk(flush, 1'b1);
    rchk(32'h5000_1300, 32'h0, i2c_regs_pkg::RESP_SLVERR);
    wr(32'h5000_1300, 32'h1, i2c_regs_pkg::RESP_SLVERR);
    $display("test reset values done");
    // Hold time read back and applied
    d = $random(seed);
    wr(i2c_regs_pkg::ADDR_DATA_HOLD_TIME, {16'h0, d[15:0]});
    rchk(i2c_regs_pkg::ADDR_DATA_HOLD_TIME, {16'h0, d[15:0]});
    chk({16'h0, hold}, {16'h0, d[15:0]});
    $display("test hold time done");
    // Enable applied two edges after commit
    wr(i2c_regs_pkg::ADDR_CONTROLLER_ENABLE, 32'h1);
    repeat (4) @(posedge i_mclk);
    chk(32'(chg_cyc - commit_cyc), 32'h2);
    chk(ctrl_en, 1'b1);
    chk(flush, 1'b0);
    rchk(i2c_regs_pkg::ADDR_CONTROLLER_ENABLE, 32'h1);
    $display("test enable done");
    // Status and levels over random core states, full and empty first
    for (i = 0; i < 24; i++) begin
      d = $random(seed);
      m_tx = (i == 0) ? DEPTH : (i == 1) ? 0 : int'(d[13:8]) % (DEPTH + 1);
      m_rx = (i == 1) ? DEPTH : (i == 0) ? 0 : int'(d[21:16]) % (DEPTH + 1);
      mst <= d[0];
      slv <= d[1];
      txl <= 6'(m_tx);
      rxl <= 6'(m_rx);
      load <= 1'b1;
      @(posedge i_mclk);
      load <= 1'b0;
      repeat (2) @(posedge i_mclk);
      es = {25'h0, d[1], d[0], m_rx == DEPTH, m_rx > 0, m_tx == 0, m_tx != DEPTH, d[0] | d[1]};
      rchk(i2c_regs_pkg::ADDR_CONTROLLER_STATUS, es);
      rchk(i2c_regs_pkg::ADDR_CONTROLLER_STATUS, es);
      rchk(i2c_regs_pkg::ADDR_TX_FILL_LEVEL, 32'(m_tx));
      rchk(i2c_regs_pkg::ADDR_RX_FILL_LEVEL, 32'(m_rx));
    end
    $display("test status done");
    // Disable in mid transfer, then let the core go idle
    mst <= 1'b1;
    slv <= 1'b0;
    txb <= 1'b1;
    rxb <= 1'b1;
    wr(i2c_regs_pkg::ADDR_IRQ_STATUS, 32'h7);
    wr(i2c_regs_pkg::ADDR_IRQ_MASK, 32'h4);
    wr(i2c_regs_pkg::ADDR_CONTROLLER_ENABLE, 32'h0);
    repeat (4) @(posedge i_mclk);
    chk(32'(chg_cyc - commit_cyc), 32'h2);
    chk({tx_disc, rx_nack, mhold, flush}, 4'b0110);
    rchk(i2c_regs_pkg::ADDR_IRQ_STATUS, 32'h0);
    txb <= 1'b0;
    rxb <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk({tx_disc, rx_nack}, 2'b10);
    mst <= 1'b0;
    repeat (4) @(posedge i_mclk);
    chk({mhold, flush, irq}, 3'b011);
    rchk(i2c_regs_pkg::ADDR_TX_FILL_LEVEL, 32'h0);
    rchk(i2c_regs_pkg::ADDR_RX_FILL_LEVEL, 32'h0);
    rchk(i2c_regs_pkg::ADDR_IRQ_STATUS, 32'h4);
    wr(i2c_regs_pkg::ADDR_IRQ_STATUS, 32'h4);
    chk(irq, 1'b0);
    $display("test disable done");
    // Events, masking and clearing by read
    wr(i2c_regs_pkg::ADDR_IRQ_MASK, 32'h0);
    evs <= 1'b1;
    evc <= 1'b1;
    @(posedge i_mclk);
    evs <= 1'b0;
    evc <= 1'b0;
    repeat (3) @(posedge i_mclk);
    chk(irq, 1'b0);
    rchk(i2c_regs_pkg::ADDR_IRQ_STATUS, 32'h3);
    wr(i2c_regs_pkg::ADDR_IRQ_MASK, 32'h3);
    chk(irq, 1'b1);
    rchk(i2c_regs_pkg::ADDR_CLEAR_START_SEEN, 32'h0);
    chk({pulse_s, pulse_c}, 2'b10);
    rchk(i2c_regs_pkg::ADDR_IRQ_STATUS, 32'h2);
    rchk(i2c_regs_pkg::ADDR_CLEAR_BROADCAST_CALL, 32'h0);
    chk({pulse_s, pulse_c}, 2'b01);
    rchk(i2c_regs_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk(irq, 1'b0);
    $display("test events done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### core/enable_sync.sv
// Delay line that applies the enable bit two core clocks after the write
`timescale 1ns/10ps
`default_nettype none
module enable_sync #(
  parameter int DEPTH = i2c_regs_pkg::ENABLE_DELAY_CYCLES
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  // Enable
  input  wire logic i_en,
  output logic      o_en
);
  logic [DEPTH-1:0] pipe_q;
  logic [DEPTH-1:0] pipe_d;

  // Shift in the written enable value
  always_comb begin
    pipe_d = {pipe_q[DEPTH-2:0], i_en};
  end

  // Register the line
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= pipe_d;
    end
  end

  assign o_en = pipe_q[DEPTH-1];
endmodule
`default_nettype wire

// ### core/i2c_enable_status_regs.sv
// AXI4-Lite register block: clear-on-read, enable, status, FIFO levels and SDA hold time
// Functional notes
// - Reading start-seen clear register clears raw interrupt bit 10.
// - Reading broadcast-call clear register clears raw interrupt bit 11.
// - Enable bit 0 turns controller on; 0 off and, once master and slave are idle, flushes both FIFOs.
// - After disable, masked interrupt bits stay until controller is idle.
// - Disable while transmitting finishes transfer, then discards transmit buffer.
// - Disable while receiving ends after current byte without acknowledge.
// - Enable change takes effect two core clocks after the write.
// - Status bit 6 is 1 while slave machine is not idle.
// - Status bit 5 is 1 while master machine is not idle.
// - Status bit 4 is 1 when receive FIFO is full.
// - Status bit 3 is 1 when receive FIFO holds an entry.
// - Status bit 2 is 1 when transmit FIFO empty; resets 1; no interrupt.
// - Status bit 1 is 1 while transmit FIFO has space; resets 1.
// - Transmit level field bits 5:0 shows transmit entries; resets zero.
// - Receive level field bits 5:0 shows receive entries; resets zero.
`timescale 1ns/10ps
`default_nettype none
module i2c_enable_status_regs #(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rstn,
  // AXI4-Lite write address
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // AXI4-Lite write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read address
  input  wire logic [31:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  // AXI4-Lite read data
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Core observations
  input  wire logic        i_master_busy,
  input  wire logic        i_slave_busy,
  input  wire logic [5:0]  i_tx_level,
  input  wire logic [5:0]  i_rx_level,
  input  wire logic        i_start_seen_irq,
  input  wire logic        i_broadcast_call_irq,
  input  wire logic        i_tx_in_byte,
  input  wire logic        i_rx_in_byte,
  // Core controls
  output logic             o_ctrl_enable,
  output logic             o_fifo_flush,
  output logic             o_tx_discard,
  output logic             o_rx_nack,
  output logic             o_start_seen_clear,
  output logic             o_broadcast_call_clear,
  output logic             o_masked_hold,
  output logic [15:0]      o_data_hold_cycles,
  // Interrupt
  output logic             o_irq
);
  // Write channel state
  logic        aw_held_q, aw_held_d;
  logic [31:0] aw_addr_q, aw_addr_d;
  logic        w_held_q, w_held_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  // Read channel state
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  // Registers
  logic        enable_q, enable_d;
  logic [15:0] hold_q, hold_d;
  logic [2:0]  evt_q, evt_d;
  logic [2:0]  mask_q, mask_d;
  logic        sclr_q, sclr_d;
  logic        gclr_q, gclr_d;
  logic        drain_q, drain_d;
  logic        active_q;
  // Derived
  logic        en_eff;
  logic        do_write;
  logic        do_read;
  logic [15:0] status;
  logic        ctrl_busy;
  logic [2:0]  evt_set;

  // Map an address to its read value, with a hit flag
  function automatic logic [32:0] read_map(input logic [31:0] a, input logic [15:0] st,
                                           input logic [5:0] txl, input logic [5:0] rxl,
                                           input logic en, input logic [15:0] hold,
                                           input logic [2:0] ev, input logic [2:0] mk);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    if (a == i2c_regs_pkg::ADDR_CLEAR_START_SEEN) begin
      r[31:0] = 32'h0000_0000;
    end else if (a == i2c_regs_pkg::ADDR_CLEAR_BROADCAST_CALL) begin
      r[31:0] = 32'h0000_0000;
    end else if (a == i2c_regs_pkg::ADDR_CONTROLLER_ENABLE) begin
      r[31:0] = {31'h0000_0000, en};
    end else if (a == i2c_regs_pkg::ADDR_CONTROLLER_STATUS) begin
      r[31:0] = {16'h0000, st};
    end else if (a == i2c_regs_pkg::ADDR_TX_FILL_LEVEL) begin
      r[31:0] = {26'h000_0000, txl};
    end else if (a == i2c_regs_pkg::ADDR_RX_FILL_LEVEL) begin
      r[31:0] = {26'h000_0000, rxl};
    end else if (a == i2c_regs_pkg::ADDR_DATA_HOLD_TIME) begin
      r[31:0] = {16'h0000, hold};
    end else if (a == i2c_regs_pkg::ADDR_IRQ_STATUS) begin
      r[31:0] = {29'h0000_0000, ev};
    end else if (a == i2c_regs_pkg::ADDR_IRQ_MASK) begin
      r[31:0] = {29'h0000_0000, mk};
    end else begin
      r = {1'b0, 32'h0000_0000};
    end
    return r;
  endfunction

  // Enable delay line: two core clocks from write to effect
  enable_sync #(
    .DEPTH (i2c_regs_pkg::ENABLE_DELAY_CYCLES)
  ) u_enable_sync (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_en   (enable_q),
    .o_en   (en_eff)
  );

  // Status word from core observations
  always_comb begin
    status = 16'h0000;
    status[i2c_regs_pkg::ST_SLAVE_BIT]    = i_slave_busy;
    status[i2c_regs_pkg::ST_MASTER_BIT]   = i_master_busy;
    status[i2c_regs_pkg::ST_RX_FULL_BIT]  = (32'(i_rx_level) >= FIFO_DEPTH);
    status[i2c_regs_pkg::ST_RX_DATA_BIT]  = (i_rx_level != 6'h00);
    status[i2c_regs_pkg::ST_TX_EMPTY_BIT] = (i_tx_level == 6'h00);
    status[i2c_regs_pkg::ST_TX_SPACE_BIT] = (32'(i_tx_level) < FIFO_DEPTH);
    status[i2c_regs_pkg::ST_ACTIVITY_BIT] = i_master_busy | i_slave_busy;
  end

  assign ctrl_busy = i_master_busy | i_slave_busy;
  assign do_write  = aw_held_q && w_held_q && !bvalid_q;
  assign do_read   = i_arvalid && !rvalid_q;

  // Local event sources: start seen, broadcast call, idle after disable
  always_comb begin
    evt_set = 3'h0;
    evt_set[i2c_regs_pkg::EV_START_SEEN]     = i_start_seen_irq;
    evt_set[i2c_regs_pkg::EV_BROADCAST_CALL] = i_broadcast_call_irq;
    evt_set[i2c_regs_pkg::EV_IDLE_REACHED]   = drain_q && !ctrl_busy;
  end

  // Bus and register next state
  always_comb begin
    logic [32:0] rm;
    rm        = 33'h0_0000_0000;
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    enable_d  = enable_q;
    hold_d    = hold_q;
    mask_d    = mask_q;
    evt_d     = evt_q;
    sclr_d    = 1'b0;
    gclr_d    = 1'b0;
    // Address and data taken in either order
    if (i_awvalid && !aw_held_q) begin
      aw_held_d = 1'b1;
      aw_addr_d = i_awaddr;
    end
    if (i_wvalid && !w_held_q) begin
      w_held_d = 1'b1;
      w_data_d = i_wdata;
      w_strb_d = i_wstrb;
    end
    // Write commit
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = i2c_regs_pkg::RESP_OKAY;
      if (aw_addr_q == i2c_regs_pkg::ADDR_CONTROLLER_ENABLE) begin
        if (w_strb_q[0]) begin
          enable_d = w_data_q[0];
        end
      end else if (aw_addr_q == i2c_regs_pkg::ADDR_DATA_HOLD_TIME) begin
        if (w_strb_q[0]) begin
          hold_d[7:0] = w_data_q[7:0];
        end
        if (w_strb_q[1]) begin
          hold_d[15:8] = w_data_q[15:8];
        end
      end else if (aw_addr_q == i2c_regs_pkg::ADDR_IRQ_MASK) begin
        if (w_strb_q[0]) begin
          mask_d = w_data_q[2:0];
        end
      end else if (aw_addr_q == i2c_regs_pkg::ADDR_IRQ_STATUS) begin
        if (w_strb_q[0]) begin
          evt_d = evt_q & ~w_data_q[2:0];
        end
      end else if (read_map(aw_addr_q, status, i_tx_level, i_rx_level, enable_q, hold_q, evt_q, mask_q)
                   == {1'b0, 32'h0000_0000}) begin
        bresp_d = i2c_regs_pkg::RESP_SLVERR;
      end
    end
    if (bvalid_q && i_bready) begin
      bvalid_d = 1'b0;
    end
    // Read: answer one cycle after the address is taken
    if (do_read) begin
      rm       = read_map(i_araddr, status, i_tx_level, i_rx_level, enable_q, hold_q, evt_q, mask_q);
      rvalid_d = 1'b1;
      rdata_d  = rm[31:0];
      rresp_d  = rm[32] ? i2c_regs_pkg::RESP_OKAY : i2c_regs_pkg::RESP_SLVERR;
      if (i_araddr == i2c_regs_pkg::ADDR_CLEAR_START_SEEN) begin
        sclr_d = 1'b1;
        evt_d[i2c_regs_pkg::EV_START_SEEN] = 1'b0;
      end
      if (i_araddr == i2c_regs_pkg::ADDR_CLEAR_BROADCAST_CALL) begin
        gclr_d = 1'b1;
        evt_d[i2c_regs_pkg::EV_BROADCAST_CALL] = 1'b0;
      end
    end else if (rvalid_q && i_rready) begin
      rvalid_d = 1'b0;
    end
    // Set wins over clear
    evt_d = evt_d | evt_set;
  end

  // Drain tracking: disabled but still busy keeps masked status alive
  always_comb begin
    drain_d = drain_q;
    if (active_q && !en_eff && ctrl_busy) begin
      drain_d = 1'b1;
    end else if (!ctrl_busy || en_eff) begin
      drain_d = 1'b0;
    end
  end

  // Register everything
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'h0;
      enable_q  <= i2c_regs_pkg::ENABLE_RESET;
      hold_q    <= i2c_regs_pkg::HOLD_RESET;
      evt_q     <= 3'h0;
      mask_q    <= 3'h0;
      sclr_q    <= 1'b0;
      gclr_q    <= 1'b0;
      drain_q   <= 1'b0;
      active_q  <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      enable_q  <= enable_d;
      hold_q    <= hold_d;
      evt_q     <= evt_d;
      mask_q    <= mask_d;
      sclr_q    <= sclr_d;
      gclr_q    <= gclr_d;
      drain_q   <= drain_d;
      active_q  <= en_eff;
    end
  end

  // Bus outputs
  assign o_awready = !aw_held_q;
  assign o_wready  = !w_held_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_arready = !rvalid_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;

  // Core control outputs
  assign o_ctrl_enable          = en_eff;
  assign o_fifo_flush           = !en_eff && !ctrl_busy;
  assign o_tx_discard           = !en_eff && !i_tx_in_byte;
  assign o_rx_nack              = !en_eff && i_rx_in_byte;
  assign o_start_seen_clear     = sclr_q;
  assign o_broadcast_call_clear = gclr_q;
  assign o_masked_hold          = drain_q;
  assign o_data_hold_cycles     = hold_q;
  assign o_irq                  = |(evt_q & mask_q);

  // Checks
  enable_delay_a : assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $changed(enable_q) |-> ##2 (o_ctrl_enable == $past(enable_q, 2)))
    else $error("enable not applied after two cycles");
  start_clear_a : assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (do_read && i_araddr == i2c_regs_pkg::ADDR_CLEAR_START_SEEN) |=> o_start_seen_clear)
    else $error("start seen clear missing");
  bcast_clear_a : assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (do_read && i_araddr == i2c_regs_pkg::ADDR_CLEAR_BROADCAST_CALL) |=> o_broadcast_call_clear)
    else $error("broadcast clear missing");
  flush_off_a : assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (!$past(enable_q, 2) && !ctrl_busy) |-> o_fifo_flush)
    else $error("fifo not flushed while off");
  tx_discard_a : assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_tx_discard == (!$past(enable_q, 2) && !i_tx_in_byte))
    else $error("transmit discard rule broken");
  rx_nack_a : assert property (@(posedge i_mclk) disable iff (!i_rstn)
    o_rx_nack == (!$past(enable_q, 2) && i_rx_in_byte))
    else $error("nack rule broken");
  slave_bit_a : assert property (@(posedge i_mclk) disable iff (!i_rstn)
    status[6] == i_slave_busy && status[5] == i_master_busy)
    else $error("activity bits wrong");
  tx_empty_a : assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (i_tx_level == 6'h00) |-> (status[2] && status[1]))
    else $error("tx empty bits wrong");
  rx_bits_a : assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (status[4] |-> status[3]) and (status[0] == (i_master_busy | i_slave_busy)))
    else $error("rx or activity bits wrong");
  hold_write_a : assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (do_write && aw_addr_q == i2c_regs_pkg::ADDR_DATA_HOLD_TIME && w_strb_q == 4'hf)
    |=> (o_data_hold_cycles == $past(w_data_q[15:0])))
    else $error("hold time not written");
  drain_keep_a : assert property (@(posedge i_mclk) disable iff (!i_rstn)
    (drain_q && ctrl_busy && !en_eff) |=> drain_q)
    else $error("masked hold dropped while busy");
  write_cov_c : cover property (@(posedge i_mclk) disable iff (!i_rstn) do_write);
  read_cov_c  : cover property (@(posedge i_mclk) disable iff (!i_rstn) o_rvalid && i_rready);
  drain_cov_c : cover property (@(posedge i_mclk) disable iff (!i_rstn) drain_q ##1 !drain_q);
  irq_cov_c   : cover property (@(posedge i_mclk) disable iff (!i_rstn) o_irq);
endmodule
`default_nettype wire

// ### shared/i2c_regs_pkg.sv
// Package: register map, field positions and reset values of the I2C enable/status block
package i2c_regs_pkg;
  // Byte addresses as printed
  localparam logic [31:0] ADDR_CLEAR_START_SEEN     = 32'h5000_1364;
  localparam logic [31:0] ADDR_CLEAR_BROADCAST_CALL = 32'h5000_1368;
  localparam logic [31:0] ADDR_CONTROLLER_ENABLE    = 32'h5000_136c;
  localparam logic [31:0] ADDR_CONTROLLER_STATUS    = 32'h5000_1370;
  localparam logic [31:0] ADDR_TX_FILL_LEVEL        = 32'h5000_1374;
  localparam logic [31:0] ADDR_RX_FILL_LEVEL        = 32'h5000_1378;
  localparam logic [31:0] ADDR_DATA_HOLD_TIME       = 32'h5000_137c;
  localparam logic [31:0] ADDR_IRQ_STATUS           = 32'h5000_13c0;
  localparam logic [31:0] ADDR_IRQ_MASK             = 32'h5000_13c4;
  // Raw interrupt bit positions
  localparam int START_SEEN_BIT     = 10;
  localparam int BROADCAST_CALL_BIT = 11;
  // Status bit positions
  localparam int ST_ACTIVITY_BIT   = 0;
  localparam int ST_TX_SPACE_BIT   = 1;
  localparam int ST_TX_EMPTY_BIT   = 2;
  localparam int ST_RX_DATA_BIT    = 3;
  localparam int ST_RX_FULL_BIT    = 4;
  localparam int ST_MASTER_BIT     = 5;
  localparam int ST_SLAVE_BIT      = 6;
  // Level field width
  localparam int LEVEL_W = 6;
  // Reset values
  localparam logic [15:0] HOLD_RESET   = 16'h0001;
  localparam logic        ENABLE_RESET = 1'b0;
  // Enable delay in core clock cycles
  localparam int ENABLE_DELAY_CYCLES = 2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sticky event bit positions in the local interrupt register
  localparam int EV_START_SEEN     = 0;
  localparam int EV_BROADCAST_CALL = 1;
  localparam int EV_IDLE_REACHED   = 2;
  localparam int EV_W              = 3;
endpackage
